// File: xfer_defs.svh
/*
 * Offsets, field positions, reset values and counts of the event-triggered
 * transfer engine. Included by the master port, the engine and the bench.
 */
`ifndef XFER_DEFS_SVH
`define XFER_DEFS_SVH

// ==========================================================================
// Register byte offsets
`define OFS_VECTOR_BASE  8'h00
`define OFS_CONTROL      8'h04
`define OFS_STATUS       8'h08
`define OFS_SOFT_REQ     8'h0C

// ==========================================================================
// Control register fields
`define CTL_STOP_BIT     0
`define CTL_FULL_BIT     1
`define CTL_RDSKIP_BIT   2

// ==========================================================================
// Reset values
`define VECTOR_BASE_RST  32'h0000_0000
`define CONTROL_RST      32'h0000_0001

// ==========================================================================
// Sources and descriptor layout
`define NUM_SOURCES      85
`define SOFT_SOURCE      84
`define DESC_BYTES       16
`define REPEAT_MAX       256
`define SHORT_LOW_TOP    32'h007F_FFFF
`define SHORT_HIGH_BASE  32'hFF80_0000

// ==========================================================================
// Descriptor mode word fields
`define MD_MODE_LSB      0
`define MD_SIZE_LSB      2
`define MD_SRC_LSB       4
`define MD_DST_LSB       6
`define MD_RPT_DST_BIT   8
`define MD_CHAIN_BIT     9
`define MD_CHAIN_ZERO    10
`define MD_IRQ_ACT_BIT   11
`define MD_IRQ_UNIT_BIT  12
`define MD_IRQ_END_BIT   13

`endif

// File: xfer_pkg.sv
/*
 * Types shared by the transfer engine and its bus front end.
 * Needs no include file; xfer_defs.svh is not used here.
 */
package xfer_pkg;
   typedef enum logic [1:0] {MODE_NORMAL, MODE_REPEAT, MODE_BLOCK, MODE_RSVD} xfer_mode_e;
   typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG, SZ_RSVD} unit_size_e;
   typedef enum logic [1:0] {ADR_FIXED, ADR_FIXED2, ADR_INC, ADR_DEC} adr_step_e;

   // Avalon-MM master request toward the internal main bus
   typedef struct packed {
      logic [31:0] address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } mbus_req_s;

   // Avalon-MM slave request from software
   typedef struct packed {
      logic [7:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
   } sbus_req_s;
endpackage : xfer_pkg

// File: xfer_master_port.sv
/*
 * One-access Avalon-MM master sequencer: takes a single read or write
 * command, holds it on the main bus until waitrequest falls, then pulses
 * done with captured read data. Same clock as the main bus.
 */
`timescale 1ns/1ps
`include "xfer_defs.svh"

module xfer_master_port
   import xfer_pkg::*;
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // Command side
   input  wire logic              cmd_valid,
   input  wire logic              cmd_write,
   input  wire logic [31:0]       cmd_addr,
   input  wire logic [31:0]       cmd_data,
   input  wire logic [3:0]        cmd_be,
   output logic                   cmd_ready,
   output logic                   done,
   output logic [31:0]            rdata,
   // Main bus
   output xfer_pkg::mbus_req_s    mreq,
   input  wire logic              m_waitrequest,
   input  wire logic [31:0]       m_readdata
);
   import xfer_pkg::*;

   logic busy;
   wire  accept = cmd_valid && !busy;
   wire  finish = busy && !m_waitrequest;

   assign cmd_ready = !busy;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy  <= 1'b0;
         mreq  <= '0;
         done  <= 1'b0;
         rdata <= 32'h0000_0000;
      end else begin
         done <= finish;
         if (finish) begin
            busy  <= 1'b0;
            mreq  <= '0;
            rdata <= m_readdata;
         end else if (accept) begin
            busy <= 1'b1;
            mreq <= '{cmd_addr, !cmd_write, cmd_write, cmd_data, cmd_be};
         end
      end
   end

   a_req_held: assert property (@(posedge clk) disable iff (rst)
      (busy && m_waitrequest) |=> $stable(mreq))
      else $error("main bus request changed while stalled");
   a_no_rw_both: assert property (@(posedge clk) disable iff (rst)
      !(mreq.read && mreq.write))
      else $error("read and write high together");
endmodule : xfer_master_port

// File: xfer_engine.sv
/*
 * Event-triggered transfer engine: per-source descriptors fetched from
 * memory at vector base + 4*source, normal/repeat/block modes, chaining,
 * write-back of changed fields and CPU interrupt requests.
 * Assumes an Avalon-MM register slave and an Avalon-MM main bus on clk.
 */
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`include "xfer_defs.svh"

// Notes on behaviour
// - Normal mode: one unit per activation
// - Repeat mode reloads address after repeat count
// - Repeat size up to 256 units
// - Block mode: whole block per activation
// - Block size one to 256 units
// - Each source owns a descriptor; request starts it
// - Chain runs following descriptors in one activation
// - Chain always or only at counter zero
// - Short mode addresses sign-extended to 16 MB
// - Full mode uses whole 32-bit space
// - Unit is byte, word or longword
// - Pass activating interrupt to CPU optionally
// - Optional CPU interrupt after each unit
// - Optional CPU interrupt at count end
// - Read skip reuses held descriptor
// - Fixed addresses are not written back
// - Module stop halts operation
// - 85 activation sources
// - Bus master reaches memory over main bus
module xfer_engine
   import xfer_pkg::*;
#(
   parameter int NSRC = `NUM_SOURCES
)(
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst,
   // Activation from the interrupt controller
   input  wire logic [NSRC-1:0]       act_req,
   output logic      [NSRC-1:0]       act_ack,
   // CPU interrupt requests
   output logic                       cpu_irq,
   output logic [6:0]                 cpu_irq_src,
   // Register slave
   input  xfer_pkg::sbus_req_s        sreq,
   output logic [31:0]                s_readdata,
   output logic                       s_waitrequest,
   // Main bus master
   output xfer_pkg::mbus_req_s        mreq,
   input  wire logic                  m_waitrequest,
   input  wire logic [31:0]           m_readdata
);
   import xfer_pkg::*;

   typedef enum logic [3:0] {IDLE, VEC, D0, D1, D2, D3, RD, WR, WB0, WB1, WB2, NEXT} state_e;
   state_e st;

   // ========================================================================
   // Registers
   logic [31:0] vbase;
   logic [31:0] ctrl;
   logic        soft_req;
   logic        ack_pend;
   wire  stopped  = ctrl[`CTL_STOP_BIT];
   wire  full_adr = ctrl[`CTL_FULL_BIT];
   wire  rd_skip  = ctrl[`CTL_RDSKIP_BIT];
   wire  wr_hit   = sreq.write && !s_waitrequest;
   // Read data is captured while the request still waits, so it stands at the taking edge
   wire  rd_hit   = sreq.read && s_waitrequest;

   assign s_waitrequest = (sreq.read || sreq.write) && !ack_pend;

   // ========================================================================
   // Descriptor held in the engine
   logic [31:0] md, sar, dar, cnt;
   logic [31:0] dptr, data;
   logic [6:0]  src, last_src;
   logic        last_valid;
   logic [8:0]  blk_left;
   logic        unit_irq;
   wire  xfer_mode_e mode  = xfer_mode_e'(md[`MD_MODE_LSB +: 2]);
   wire  unit_size_e usz   = unit_size_e'(md[`MD_SIZE_LSB +: 2]);
   wire  adr_step_e  sstep = adr_step_e'(md[`MD_SRC_LSB +: 2]);
   wire  adr_step_e  dstep = adr_step_e'(md[`MD_DST_LSB +: 2]);
   wire  [8:0]  rsize      = (md[31:24] == 8'h00) ? 9'h100 : {1'b0, md[31:24]};
   wire  [15:0] cnt_lo     = cnt[15:0];

   function automatic logic [31:0] step_adr(input logic [31:0] a, input adr_step_e s,
                                           input unit_size_e z, input logic full);
      logic [31:0] inc;
      logic [31:0] r;
      inc = (z == SZ_BYTE) ? 32'h0000_0001 : (z == SZ_WORD) ? 32'h0000_0002 : 32'h0000_0004;
      r = (s == ADR_INC) ? a + inc : (s == ADR_DEC) ? a - inc : a;
      step_adr = full ? r : {{8{r[23]}}, r[23:0]};
   endfunction : step_adr

   function automatic logic [31:0] map_adr(input logic [31:0] a, input logic full);
      map_adr = full ? a : {{8{a[23]}}, a[23:0]};
   endfunction : map_adr

   // ========================================================================
   // Source select: lowest pending source wins; the soft request is last
   logic [NSRC-1:0] pend;
   logic [6:0]      pick;
   logic            any;
   assign pend = act_req | ({{(NSRC-1){1'b0}}, soft_req} << `SOFT_SOURCE);
   always_comb begin
      pick = 7'h00;
      any  = 1'b0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (pend[i]) begin
            pick = 7'(i);
            any  = 1'b1;
         end
      end
   end

   // ========================================================================
   // Main bus sequencer
   logic        c_valid, c_write, c_ready, c_done;
   logic [31:0] c_addr, c_data, c_rdata;
   logic [3:0]  c_be;
   wire  [3:0]  unit_be = (usz == SZ_BYTE) ? 4'h1 : (usz == SZ_WORD) ? 4'h3 : 4'hF;

   xfer_master_port u_port (
      .clk           (clk),
      .rst           (rst),
      .cmd_valid     (c_valid),
      .cmd_write     (c_write),
      .cmd_addr      (c_addr),
      .cmd_data      (c_data),
      .cmd_be        (c_be),
      .cmd_ready     (c_ready),
      .done          (c_done),
      .rdata         (c_rdata),
      .mreq          (mreq),
      .m_waitrequest (m_waitrequest),
      .m_readdata    (m_readdata)
   );

   logic issued;
   wire  bus_st = (st != IDLE) && (st != NEXT);
   assign c_valid = bus_st && !issued;
   assign c_write = (st == WR) || (st == WB0) || (st == WB1) || (st == WB2);
   assign c_be    = (st == RD || st == WR) ? unit_be : 4'hF;
   always_comb begin
      unique case (st)
         VEC:     c_addr = vbase + {23'h0, src, 2'b00};
         D0:      c_addr = dptr;
         D1:      c_addr = dptr + 32'h0000_0004;
         D2:      c_addr = dptr + 32'h0000_0008;
         D3:      c_addr = dptr + 32'h0000_000C;
         RD:      c_addr = map_adr(sar, full_adr);
         WR:      c_addr = map_adr(dar, full_adr);
         WB0:     c_addr = dptr + 32'h0000_0004;
         WB1:     c_addr = dptr + 32'h0000_0008;
         WB2:     c_addr = dptr + 32'h0000_000C;
         default: c_addr = 32'h0000_0000;
      endcase
   end
   always_comb begin
      unique case (st)
         WR:      c_data = data;
         WB0:     c_data = sar;
         WB1:     c_data = dar;
         WB2:     c_data = cnt;
         default: c_data = 32'h0000_0000;
      endcase
   end

   // ========================================================================
   // Unit completion arithmetic
   wire  rpt_end   = (mode == MODE_REPEAT) && (cnt[7:0] == 8'h01 || (cnt[7:0] == 8'h00 && rsize == 9'h100));
   wire  rpt_dst   = md[`MD_RPT_DST_BIT];
   wire  [31:0] sar_n = step_adr(sar, sstep, usz, full_adr);
   wire  [31:0] dar_n = step_adr(dar, dstep, usz, full_adr);
   wire  [31:0] back  = {23'h0, rsize} << usz;
   wire  [31:0] sar_r = (sstep == ADR_INC) ? sar_n - back : sar_n + back;
   wire  [31:0] dar_r = (dstep == ADR_INC) ? dar_n - back : dar_n + back;
   wire  blk_last  = (mode != MODE_BLOCK) || (blk_left == 9'h001);
   wire  [31:0] cnt_n = (mode == MODE_REPEAT) ? (rpt_end ? {cnt[31:8], rsize[7:0]} : cnt - 32'h1)
                      : (mode == MODE_BLOCK) ? {cnt[31:16], cnt_lo - 16'h1} : cnt - 32'h1;
   wire  cnt_zero  = (mode == MODE_REPEAT) ? 1'b0 : (mode == MODE_BLOCK) ? (cnt_lo == 16'h0000) : (cnt == 32'h0);
   wire  chain_go  = md[`MD_CHAIN_BIT] && (!md[`MD_CHAIN_ZERO] || cnt_zero);
   wire  rd_done   = (st == RD) && c_done;
   wire  wr_done   = (st == WR) && c_done;

   // ========================================================================
   // Sequencer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st <= IDLE; issued <= 1'b0; dptr <= 32'h0; src <= 7'h00; data <= 32'h0;
         md <= 32'h0; sar <= 32'h0; dar <= 32'h0; cnt <= 32'h0; blk_left <= 9'h000;
         last_src <= 7'h00; last_valid <= 1'b0; act_ack <= '0; unit_irq <= 1'b0;
      end else begin
         act_ack  <= '0;
         unit_irq <= 1'b0;
         if (c_valid && c_ready) issued <= 1'b1;
         if (c_done) issued <= 1'b0;
         unique case (st)
            IDLE: if (any && !stopped) begin
               src      <= pick;
               act_ack[pick] <= 1'b1;
               if (rd_skip && last_valid && last_src == pick) st <= RD;
               else st <= VEC;
            end
            VEC: if (c_done) begin dptr <= c_rdata; st <= D0; end
            D0:  if (c_done) begin md  <= c_rdata; st <= D1; end
            D1:  if (c_done) begin sar <= c_rdata; st <= D2; end
            D2:  if (c_done) begin dar <= c_rdata; st <= D3; end
            D3:  if (c_done) begin
               cnt <= c_rdata; st <= RD; last_src <= src; last_valid <= 1'b1;
               blk_left <= (md[31:24] == 8'h00) ? 9'h100 : {1'b0, md[31:24]};
            end
            RD: if (rd_done) begin data <= c_rdata; st <= WR; end
            WR: if (wr_done) begin
               unit_irq <= md[`MD_IRQ_UNIT_BIT];
               sar <= (rpt_end && !rpt_dst && sstep[1]) ? sar_r : sar_n;
               dar <= (rpt_end && rpt_dst && dstep[1]) ? dar_r : dar_n;
               if (mode == MODE_BLOCK) blk_left <= blk_left - 9'h001;
               if (blk_last) begin
                  cnt <= cnt_n;
                  st  <= sstep[1] ? WB0 : dstep[1] ? WB1 : WB2;
               end else st <= RD;
            end
            WB0: if (c_done) st <= dstep[1] ? WB1 : WB2;
            WB1: if (c_done) st <= WB2;
            WB2: if (c_done) st <= NEXT;
            NEXT: if (chain_go) begin
               dptr <= dptr + `DESC_BYTES;
               st   <= D0;
            end else st <= IDLE;
            default: st <= IDLE;
         endcase
      end
   end

   // ========================================================================
   // CPU interrupt requests, one-cycle pulses
   wire end_irq = (st == NEXT) && !chain_go && ((md[`MD_IRQ_END_BIT] && cnt_zero) || md[`MD_IRQ_ACT_BIT]);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cpu_irq     <= 1'b0;
         cpu_irq_src <= 7'h00;
      end else begin
         cpu_irq     <= unit_irq || end_irq;
         cpu_irq_src <= src;
      end
   end

   // ========================================================================
   // Register slave: answer one cycle after the request appears
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         vbase <= `VECTOR_BASE_RST; ctrl <= `CONTROL_RST; soft_req <= 1'b0;
         ack_pend <= 1'b0; s_readdata <= 32'h0;
      end else begin
         ack_pend <= (sreq.read || sreq.write) && !ack_pend;
         if (st == IDLE && any && !stopped && pick == 7'(`SOFT_SOURCE)) soft_req <= 1'b0;
         if (wr_hit) begin
            unique case (sreq.address)
               `OFS_VECTOR_BASE: vbase <= {sreq.writedata[31:2], 2'b00};
               `OFS_CONTROL:     ctrl  <= {29'h0, sreq.writedata[2:0]};
               `OFS_SOFT_REQ:    if (sreq.writedata[0]) soft_req <= 1'b1;
               default: ;
            endcase
         end
         if (rd_hit) begin
            unique case (sreq.address)
               `OFS_VECTOR_BASE: s_readdata <= vbase;
               `OFS_CONTROL:     s_readdata <= ctrl;
               `OFS_STATUS:      s_readdata <= {16'h0, 1'b0, src, 4'h0, st != IDLE, soft_req, 2'b00};
               default:          s_readdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ========================================================================
   // Checks
   a_stop_idle: assert property (@(posedge clk) disable iff (rst)
      (st == IDLE && stopped) |=> st == IDLE)
      else $error("engine left idle while stopped");
   a_ack_one: assert property (@(posedge clk) disable iff (rst)
      $onehot0(act_ack))
      else $error("more than one activation acknowledged");
   a_block_back: assert property (@(posedge clk) disable iff (rst)
      (wr_done && mode == MODE_BLOCK && !blk_last) |=> st == RD)
      else $error("block ended early");
   a_normal_one: assert property (@(posedge clk) disable iff (rst)
      (wr_done && mode == MODE_NORMAL) |=> st != RD)
      else $error("normal mode moved a second unit");
   a_cnt_dec: assert property (@(posedge clk) disable iff (rst)
      (wr_done && mode == MODE_NORMAL) |=> cnt == $past(cnt) - 32'h1)
      else $error("counter not decremented");
   a_fixed_skip: assert property (@(posedge clk) disable iff (rst)
      (wr_done && blk_last && !sstep[1]) |=> st != WB0)
      else $error("fixed source written back");
   a_unit_irq: assert property (@(posedge clk) disable iff (rst)
      (wr_done && md[`MD_IRQ_UNIT_BIT]) |-> ##2 cpu_irq)
      else $error("unit interrupt missing");
   a_chain_zero: assert property (@(posedge clk) disable iff (rst)
      (st == NEXT && md[`MD_CHAIN_BIT] && md[`MD_CHAIN_ZERO] && !cnt_zero) |=> st == IDLE)
      else $error("chain ran with nonzero counter");
   c_block: cover property (@(posedge clk) wr_done && mode == MODE_BLOCK && blk_last);
   c_chain: cover property (@(posedge clk) st == NEXT && chain_go);
   c_skip:  cover property (@(posedge clk) st == IDLE ##1 st == RD);
endmodule : xfer_engine

// File: xfer_mem_model.sv
/*
 * Main-bus memory model standing behind the transfer engine: a byte-wide
 * sparse store answering Avalon-MM reads and writes after a set wait.
 * Assumes xfer_pkg is compiled first and that the engine shares clk.
 */
`timescale 1ns/1ps

// ==========================================================================
// Memory slave
module xfer_mem_model
   import xfer_pkg::*;
#(
   parameter int WAIT_CYCLES = 1
)(
   // Clock and reset
   input  wire logic           clk,
   input  wire logic           rst,
   // Main bus slave
   input  xfer_pkg::mbus_req_s mreq,
   output logic                m_waitrequest,
   output logic [31:0]         m_readdata
);
   import xfer_pkg::*;
   bit   [7:0]  mem [bit [31:0]];
   int          dly = WAIT_CYCLES;
   int          wait_cnt;
   int          wr_count = 0;
   logic [31:0] last_rd;
   wire         bus_req = mreq.read | mreq.write;
   wire         accept  = bus_req && (wait_cnt >= dly);

   // Unwritten bytes read as zero without touching the sparse store
   function automatic logic [31:0] peek32(input logic [31:0] a);
      logic [31:0] r;
      for (int i = 0; i < 4; i++) r[8*i +: 8] = mem.exists(a + i) ? mem[a + i] : 8'h00;
      return r;
   endfunction : peek32

   task automatic poke32(input logic [31:0] a, input logic [31:0] d);
      for (int i = 0; i < 4; i++) mem[a+i] = d[8*i +: 8];
   endtask : poke32

   assign m_waitrequest = !accept;
   // Idle read data is the inverse of the last word, so a late capture shows
   assign m_readdata = (mreq.read && accept) ? peek32(mreq.address) : ~last_rd;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wait_cnt <= 0;
         last_rd  <= '0;
      end else if (accept) begin
         wait_cnt <= 0;
         if (mreq.write) begin
            for (int i = 0; i < 4; i++) if (mreq.byteenable[i]) mem[mreq.address+i] = mreq.writedata[8*i +: 8];
            wr_count++;
         end else begin
            last_rd <= m_readdata;
         end
      end else if (bus_req) begin
         wait_cnt <= wait_cnt + 1;
      end
   end
endmodule : xfer_mem_model

// File: xfer_engine_tb.sv
/*
 * Self-checking bench of the transfer engine: register tasks on the slave
 * bus, descriptors placed in the memory model, activations by source.
 * Assumes xfer_pkg, xfer_defs.svh and xfer_mem_model are available.
 */
`timescale 1ns/1ps
`include "xfer_defs.svh"
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin errors++; \
   $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end

// ==========================================================================
// Bench top
module xfer_engine_tb;
   import xfer_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [84:0] act_req = '0;
   logic [84:0] act_ack;
   logic        cpu_irq;
   logic [6:0]  cpu_irq_src;
   sbus_req_s   sreq = '0;
   logic [31:0] s_readdata;
   logic        s_waitrequest;
   mbus_req_s   mreq;
   logic        m_waitrequest;
   logic [31:0] m_readdata;
   int          errors = 0;
   int          checks_done = 0;
   int          irq_n = 0;
   int          wc;
   logic [31:0] v;

   always #50 clk = ~clk;
   always @(posedge clk) if (cpu_irq === 1'b1) irq_n++;

   xfer_engine u_xfer_engine (.clk(clk), .rst(rst), .act_req(act_req), .act_ack(act_ack), .cpu_irq(cpu_irq),
      .cpu_irq_src(cpu_irq_src), .sreq(sreq), .s_readdata(s_readdata), .s_waitrequest(s_waitrequest),
      .mreq(mreq), .m_waitrequest(m_waitrequest), .m_readdata(m_readdata));
   xfer_mem_model u_xfer_mem_model (.clk(clk), .rst(rst), .mreq(mreq), .m_waitrequest(m_waitrequest),
      .m_readdata(m_readdata));

   // ==========================================================================
   // Access tasks
   task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      sreq <= '{address: a, read: !wr, write: wr, writedata: d};
      // Values read right at the edge are the ones the slave sampled there
      do @(posedge clk); while (s_waitrequest !== 1'b0);
      q = s_readdata;
      sreq <= '0;
   endtask : bus_xfer

   function automatic logic [31:0] peek(input logic [31:0] a);
      return u_xfer_mem_model.peek32(a);
   endfunction : peek

   task automatic poke(input logic [31:0] a, input logic [31:0] d);
      u_xfer_mem_model.poke32(a, d);
   endtask : poke

   task automatic desc(input logic [31:0] src, ptr, md, sar, dar, cnt);
      poke(32'h0000_1000 + 4*src, ptr);
      poke(ptr, md);
      poke(ptr + 4, sar);
      poke(ptr + 8, dar);
      poke(ptr + 12, cnt);
   endtask : desc

   // Busy and soft pending both clear before the next scenario may start
   task automatic wait_idle;
      do bus_xfer(1'b0, `OFS_STATUS, 32'h0, v); while (v[3:2] !== 2'b00);
   endtask : wait_idle

   task automatic activate(input int src);
      @(posedge clk);
      act_req[src] <= 1'b1;
      do @(negedge clk); while (act_ack[src] !== 1'b1);
      @(posedge clk);
      act_req[src] <= 1'b0;
      wait_idle();
   endtask : activate

   task automatic close_out;
      if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : close_out

   // ==========================================================================
   // Scenarios
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      bus_xfer(1'b0, `OFS_VECTOR_BASE, 32'h0, v);
      `CHK("vector_base_rst", `VECTOR_BASE_RST, v)
      bus_xfer(1'b0, `OFS_CONTROL, 32'h0, v);
      `CHK("control_rst", `CONTROL_RST, v)
      bus_xfer(1'b1, 8'h10, 32'hFFFF_FFFF, v);
      bus_xfer(1'b0, 8'h10, 32'h0, v);
      `CHK("unmapped", 32'h0, v)
      bus_xfer(1'b1, `OFS_VECTOR_BASE, 32'h0000_1000, v);
      bus_xfer(1'b0, `OFS_VECTOR_BASE, 32'h0, v);
      `CHK("vector_base_wr", 32'h0000_1000, v)
      bus_xfer(1'b1, `OFS_CONTROL, 32'h2, v);
      // Normal longword, both incrementing, slow memory
      u_xfer_mem_model.dly = 3;
      poke(32'h3000, 32'hA5A5_1234);
      poke(32'h3004, 32'h5A5A_0000);
      desc(5, 32'h2000, 32'h0000_10A8, 32'h3000, 32'h4000, 3);
      activate(5);
      `CHK("normal_data", 32'hA5A5_1234, peek(32'h4000))
      `CHK("normal_one_unit", 32'h0, peek(32'h4004))
      `CHK("normal_sar", 32'h3004, peek(32'h2004))
      `CHK("normal_dar", 32'h4004, peek(32'h2008))
      `CHK("normal_cnt", 32'h2, peek(32'h200C))
      `CHK("unit_irq", 1, irq_n)
      `CHK("irq_src", 7'd5, cpu_irq_src)
      // Block of four bytes, destination decrementing, prompt memory
      u_xfer_mem_model.dly = 0;
      irq_n = 0;
      poke(32'h3100, 32'h4433_2211);
      desc(6, 32'h2100, 32'h0400_20E2, 32'h3100, 32'h4103, 1);
      activate(6);
      `CHK("block_data", 32'h1122_3344, peek(32'h4100))
      `CHK("block_sar", 32'h3104, peek(32'h2104))
      `CHK("block_dar", 32'h40FF, peek(32'h2108))
      `CHK("block_cnt", 32'h0, peek(32'h210C))
      `CHK("end_irq", 1, irq_n)
      // Repeat of two words on the source side, destination fixed
      poke(32'h3200, 32'hBBBB_AAAA);
      desc(7, 32'h2200, 32'h0200_0025, 32'h3200, 32'h4200, 2);
      wc = u_xfer_mem_model.wr_count;
      activate(7);
      `CHK("rpt_writes", 3, u_xfer_mem_model.wr_count - wc)
      `CHK("rpt_sar1", 32'h3202, peek(32'h2204))
      activate(7);
      `CHK("rpt_sar2", 32'h3200, peek(32'h2204))
      `CHK("rpt_data", 32'h0000_BBBB, peek(32'h4200))
      // Chain always, chain at zero with count left, chain at zero reached
      poke(32'h3310, 32'hC0DE_0000);
      for (int k = 0; k < 3; k++) begin
         poke(32'h4310, 32'h0);
         desc(8, 32'h2300, (k == 0) ? 32'h208 : 32'h608, 32'h3300, 32'h4300, 3 - k);
         desc(0, 32'h2310, 32'h8, 32'h3310, 32'h4310, 5);
         activate(8);
         `CHK("chain_next", (k == 1) ? 32'h0 : 32'hC0DE_0000, peek(32'h4310))
      end
      // Soft request held off by module stop, then run in full address mode
      bus_xfer(1'b1, `OFS_CONTROL, 32'h3, v);
      irq_n = 0;
      poke(32'h3400, 32'h1234_5678);
      desc(`SOFT_SOURCE, 32'h2400, 32'h0808, 32'h3400, 32'h00FF_FFF4, 1);
      bus_xfer(1'b1, `OFS_SOFT_REQ, 32'h1, v);
      repeat (30) @(posedge clk);
      `CHK("stopped", 32'h0, peek(32'h00FF_FFF4))
      bus_xfer(1'b0, `OFS_STATUS, 32'h0, v);
      `CHK("soft_pending", 1'b1, v[2])
      bus_xfer(1'b1, `OFS_CONTROL, 32'h2, v);
      wait_idle();
      `CHK("full_addr", 32'h1234_5678, peek(32'h00FF_FFF4))
      `CHK("act_irq", 1, irq_n)
      `CHK("soft_src", 7'd84, cpu_irq_src)
      // Short address mode with read skip: held descriptor is reused
      bus_xfer(1'b1, `OFS_CONTROL, 32'h4, v);
      poke(32'h3500, 32'hCAFE_F00D);
      desc(9, 32'h2500, 32'h8, 32'h3500, 32'h00FF_FFF0, 5);
      activate(9);
      `CHK("short_high", 32'hCAFE_F00D, peek(32'hFFFF_FFF0))
      poke(32'h2508, 32'h4500);
      activate(9);
      `CHK("skip_held", 32'h0, peek(32'h4500))
      close_out();
   end

   initial begin
      #6_000_000;
      errors++;
      close_out();
   end
endmodule : xfer_engine_tb
